//--- design/cmbf_pkg.sv
package cmbf_pkg;

    // register byte addresses on the bus
    localparam logic [8:0] CMBF_ADR_CTRL     = 9'h000;
    localparam logic [8:0] CMBF_ADR_RX_FLAGS = 9'h004;
    localparam logic [8:0] CMBF_ADR_TX_FLAGS = 9'h008;
    localparam logic [8:0] CMBF_ADR_TX_CTRL  = 9'h00c;
    localparam logic [8:0] CMBF_ADR_ACODE    = 9'h010;
    localparam logic [8:0] CMBF_ADR_AMASK    = 9'h014;
    localparam logic [8:0] CMBF_ADR_FOREGROUND_RECEIVE_BUFFER     = 9'h040;
    localparam logic [8:0] CMBF_ADR_TXBUF    = 9'h080;
    localparam logic [8:0] CMBF_ADR_TXEND    = 9'h140;

    // message layout: 4 identifier bytes, length, 8 data bytes
    localparam int         CMBF_MSG_BYTES = 13;
    localparam logic [3:0] CMBF_LOCAL_PRIORITY_FIELD_IDX  = 4'hd;
    localparam logic [3:0] CMBF_ID_BYTES  = 4'h4;

    // control register fields
    localparam int CMBF_CTRL_MODE  = 0;
    localparam int CMBF_CTRL_LOOP  = 2;
    localparam int CMBF_CTRL_RXIE  = 4;
    localparam int CMBF_CTRL_OVRIE = 5;
    localparam int CMBF_CTRL_TXIE  = 8;

    // flag register fields
    localparam int CMBF_RXF_BIT  = 0;
    localparam int CMBF_OVR_BIT  = 1;
    localparam int CMBF_HIT_LSB  = 4;
    localparam int CMBF_ABAK_LSB = 4;

    // reset values
    localparam logic [10:0] CMBF_CTRL_RST = 11'h000;
    localparam logic [2:0]  CMBF_TXE_RST  = 3'h7;
    localparam logic [31:0] CMBF_ACC_RST  = 32'h00000000;

    typedef enum logic [1:0] {
        CMBF_FILT_32     = 2'b00,
        CMBF_FILT_16     = 2'b01,
        CMBF_FILT_8      = 2'b10,
        CMBF_FILT_CLOSED = 2'b11
    } cmbf_filt_type;

    typedef enum logic {
        CMBF_TX_IDLE   = 1'b0,
        CMBF_TX_ACTIVE = 1'b1
    } cmbf_tx_state_type;

    // byte strobe from the protocol engine while receiving
    typedef struct packed {
        logic       we;
        logic [3:0] idx;
        logic [7:0] data;
    } cmbf_rx_byte_type;

    // end of a received frame
    typedef struct packed {
        logic valid;
        logic ok;
        logic own;
    } cmbf_rx_end_type;

    // transmit progress from the protocol engine
    typedef struct packed {
        logic arb_start;
        logic done_ok;
        logic fail;
    } cmbf_tx_stat_type;

endpackage

//--- design/cmbf_top.sv
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
module cmbf_top
    import cmbf_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    input  wire logic              WE_I,
    input  wire logic [8:0]        ADR_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic [31:0]       DAT_I,
    output logic      [31:0]       DAT_O,
    output logic                   ACK_O,
    input  wire logic              CAN_RX,
    output logic                   CAN_TX,
    output logic                   RX_LEVEL,
    input  wire logic              TX_DOMINANT,
    output logic                   ACK_ALLOW,
    input  wire cmbf_rx_byte_type  RX_BYTE,
    input  wire cmbf_rx_end_type   RX_END,
    input  wire cmbf_tx_stat_type  TX_STAT,
    output logic                   TX_REQUEST,
    input  wire logic [3:0]        TX_BYTE_IDX,
    output logic      [7:0]        TX_BYTE,
    output logic                   RX_IRQ,
    output logic                   TX_IRQ,
    output logic                   ERR_IRQ
);

    // one identifier byte against code and mask, mask one is don't care
    function automatic logic byte_match(input logic [7:0] id,
                                        input logic [7:0] code,
                                        input logic [7:0] mask);
        return ((id ^ code) & ~mask) == 8'h00;
    endfunction

    logic [7:0]        bg_mem [CMBF_MSG_BYTES];
    logic [7:0]        fg_mem [CMBF_MSG_BYTES];
    logic [7:0]        tx_mem [3][CMBF_MSG_BYTES + 1];
    logic [7:0]        id_q   [4];
    logic [10:0]       ctrl_q;
    logic [31:0]       acode_q;
    logic [31:0]       amask_q;
    logic              rxf_q;
    logic              ovr_q;
    logic              bg_full_q;
    logic [1:0]        hit_q;
    logic [1:0]        bg_hit_q;
    logic [2:0]        txe_q;
    logic [2:0]        abak_q;
    logic [2:0]        abort_request_flag_q;
    logic [1:0]        sel_q;
    cmbf_tx_state_type tx_state_q;
    logic              ack_q;
    logic [31:0]       dat_q;
    logic [31:0]       rd_d;
    logic              rx_meta_q;
    logic              rx_sync_q;
    logic              can_tx_q;
    logic [7:0]        tx_byte_q;
    cmbf_filt_type     mode;
    logic              loop_en;
    logic [3:0]        hits;
    logic              any_hit;
    logic [1:0]        hit_idx;
    logic              accepted;
    logic              copy_now;
    logic              copy_pend;
    logic              wb_req;
    logic              wb_wr;
    logic [8:0]        tx_off;
    logic              tx_hit;
    logic [1:0]        tx_b;
    logic [3:0]        tx_i;
    logic              fg_hit;
    logic [3:0]        fg_i;
    logic [2:0]        pend;
    logic [1:0]        best;
    logic              wr_rx_flags;
    logic              wr_tx_flags;

    assign mode    = cmbf_filt_type'(ctrl_q[CMBF_CTRL_MODE +: 2]);
    assign loop_en = ctrl_q[CMBF_CTRL_LOOP];

    // mode picks which code bytes meet which id bytes
    always_comb
    begin
        hits = 4'h0;
        case (mode)
            CMBF_FILT_32:
                hits[0] = byte_match(id_q[0], acode_q[7:0], amask_q[7:0])
                    & byte_match(id_q[1], acode_q[15:8], amask_q[15:8])
                    & byte_match(id_q[2], acode_q[23:16], amask_q[23:16])
                    & byte_match(id_q[3], acode_q[31:24], amask_q[31:24]);
            CMBF_FILT_16:
            begin
                hits[0] = byte_match(id_q[0], acode_q[7:0], amask_q[7:0])
                    & byte_match(id_q[1], acode_q[15:8], amask_q[15:8]);
                hits[1] = byte_match(id_q[0], acode_q[23:16], amask_q[23:16])
                    & byte_match(id_q[1], acode_q[31:24], amask_q[31:24]);
            end
            CMBF_FILT_8:
                for (int k = 0; k < 4; k++)
                    hits[k] = byte_match(id_q[0], acode_q[8*k +: 8],
                                         amask_q[8*k +: 8]);
            default:
                hits = 4'h0;
        endcase
    end

    // lowest numbered filter wins, binary coded
    always_comb
    begin
        if (hits[0])
            hit_idx = 2'h0;
        else if (hits[1])
            hit_idx = 2'h1;
        else if (hits[2])
            hit_idx = 2'h2;
        else
            hit_idx = 2'h3;
    end

    assign any_hit = |hits;

    // own frames only count in loop-back
    assign accepted = RX_END.valid & RX_END.ok & any_hit
                      & (~RX_END.own | loop_en);
    // copy only into a free foreground
    assign copy_now  = accepted & ~bg_full_q & ~rxf_q;
    assign copy_pend = bg_full_q & ~rxf_q;

    // no acknowledge for own frame outside loop-back
    assign ACK_ALLOW = (tx_state_q == CMBF_TX_IDLE) | loop_en;

    // bus slave: one-cycle registered answer, held off for one cycle after
    assign wb_req = CYC_I & STB_I & ~ack_q;
    assign wb_wr  = wb_req & WE_I;
    assign tx_off = ADR_I - CMBF_ADR_TXBUF;
    assign tx_b   = tx_off[7:6];
    assign tx_i   = tx_off[5:2];
    assign tx_hit = (ADR_I >= CMBF_ADR_TXBUF) & (ADR_I < CMBF_ADR_TXEND)
                    & (tx_i <= CMBF_LOCAL_PRIORITY_FIELD_IDX) & (ADR_I[1:0] == 2'b00);
    assign fg_i   = ADR_I[5:2];
    assign fg_hit = (ADR_I[8:6] == CMBF_ADR_FOREGROUND_RECEIVE_BUFFER[8:6])
                    & (fg_i < CMBF_LOCAL_PRIORITY_FIELD_IDX) & (ADR_I[1:0] == 2'b00);
    assign wr_rx_flags = wb_wr & SEL_I[0] & (ADR_I == CMBF_ADR_RX_FLAGS);
    assign wr_tx_flags = wb_wr & SEL_I[0] & (ADR_I == CMBF_ADR_TX_FLAGS);

    // read mux, unmapped reads return zero
    always_comb
    begin
        rd_d = 32'h00000000;
        if (tx_hit)
            rd_d[7:0] = tx_mem[tx_b][tx_i];
        else if (fg_hit)
            rd_d[7:0] = fg_mem[fg_i];
        else
            case (ADR_I)
                CMBF_ADR_CTRL:
                    rd_d[10:0] = ctrl_q;
                CMBF_ADR_RX_FLAGS:
                begin
                    rd_d[CMBF_RXF_BIT] = rxf_q;
                    rd_d[CMBF_OVR_BIT] = ovr_q;
                    rd_d[CMBF_HIT_LSB +: 2] = hit_q;
                end
                CMBF_ADR_TX_FLAGS:
                begin
                    rd_d[2:0] = txe_q;
                    rd_d[CMBF_ABAK_LSB +: 3] = abak_q;
                end
                CMBF_ADR_TX_CTRL:
                    rd_d[2:0] = abort_request_flag_q;
                CMBF_ADR_ACODE:
                    rd_d = acode_q;
                CMBF_ADR_AMASK:
                    rd_d = amask_q;
                default:
                    rd_d = 32'h00000000;
            endcase
    end

    // bus answer registers
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= wb_req;
            dat_q <= wb_req ? rd_d : dat_q;
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    // configuration registers, byte lanes honoured on the 32-bit ones
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ctrl_q  <= CMBF_CTRL_RST;
            acode_q <= CMBF_ACC_RST;
            amask_q <= CMBF_ACC_RST;
        end
        else if (wb_wr)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (SEL_I[b] && ADR_I == CMBF_ADR_ACODE)
                    acode_q[8*b +: 8] <= DAT_I[8*b +: 8];
                if (SEL_I[b] && ADR_I == CMBF_ADR_AMASK)
                    amask_q[8*b +: 8] <= DAT_I[8*b +: 8];
            end
            if (ADR_I == CMBF_ADR_CTRL && SEL_I[0])
                ctrl_q[7:0] <= DAT_I[7:0];
            if (ADR_I == CMBF_ADR_CTRL && SEL_I[1])
                ctrl_q[10:8] <= DAT_I[10:8];
        end
    end

    // pin sync: first stage feeds only the second
    // receive pin brought in through two flops
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= CAN_RX;
            rx_sync_q <= rx_meta_q;
        end
    end

    assign RX_LEVEL = rx_sync_q;

    // dominant request drives pin low, recessive after reset
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            can_tx_q <= 1'b1;
        else
            can_tx_q <= ~TX_DOMINANT;
    end

    assign CAN_TX = can_tx_q;

    // incoming bytes land in background, id kept for the filter
    // background frozen while it holds a pending accepted frame
    always_ff @(posedge CLK)
    begin
        if (RX_BYTE.we && RX_BYTE.idx < CMBF_ID_BYTES)
            id_q[RX_BYTE.idx[1:0]] <= RX_BYTE.data;
        if (RX_BYTE.we && !bg_full_q && RX_BYTE.idx < CMBF_LOCAL_PRIORITY_FIELD_IDX)
            bg_mem[RX_BYTE.idx] <= RX_BYTE.data;
    end

    // foreground copy from background in one cycle
    always_ff @(posedge CLK)
    begin
        if (copy_now || copy_pend)
            for (int i = 0; i < CMBF_MSG_BYTES; i++)
                fg_mem[i] <= bg_mem[i];
    end

    // hit index follows the frame into the foreground
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            hit_q    <= 2'h0;
            bg_hit_q <= 2'h0;
        end
        else
        begin
            if (copy_now)
                hit_q <= hit_idx;
            else if (copy_pend)
                hit_q <= bg_hit_q;
            if (accepted && !bg_full_q && rxf_q)
                bg_hit_q <= hit_idx;
        end
    end

    // receive flags; a set in the clear cycle wins
    // write one clears, overrun kept while both buffers full
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rxf_q     <= 1'b0;
            ovr_q     <= 1'b0;
            bg_full_q <= 1'b0;
        end
        else
        begin
            if (copy_now || copy_pend)
                rxf_q <= 1'b1;
            else if (wr_rx_flags && DAT_I[CMBF_RXF_BIT])
                rxf_q <= 1'b0;
            if (accepted && bg_full_q)
                ovr_q <= 1'b1;
            else if (wr_rx_flags && DAT_I[CMBF_OVR_BIT] && !bg_full_q)
                ovr_q <= 1'b0;
            if (accepted && !bg_full_q && rxf_q)
                bg_full_q <= 1'b1;
            else if (copy_pend)
                bg_full_q <= 1'b0;
        end
    end

    // software fills only empty buffers, priority at index 13
    always_ff @(posedge CLK)
    begin
        if (wb_wr && tx_hit && SEL_I[0] && txe_q[tx_b])
            tx_mem[tx_b][tx_i] <= DAT_I[7:0];
    end

    // smallest priority value among pending, lowest index on a tie
    assign pend = ~txe_q;
    always_comb
    begin
        best = 2'h0;
        for (int i = 2; i >= 0; i--)
            if (pend[i] && (!pend[best] ||
                tx_mem[i][CMBF_LOCAL_PRIORITY_FIELD_IDX] <= tx_mem[best][CMBF_LOCAL_PRIORITY_FIELD_IDX]))
                best = 2'(i);
    end

    assign TX_REQUEST = |pend;

    // selection redone on every arbitration start, failures retry
    // lost arbitration arrives as fail; frame comes in as receive
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            tx_state_q <= CMBF_TX_IDLE;
            sel_q      <= 2'h0;
        end
        else
            case (tx_state_q)
                CMBF_TX_IDLE:
                    if (TX_STAT.arb_start && |pend)
                    begin
                        sel_q      <= best;
                        tx_state_q <= CMBF_TX_ACTIVE;
                    end
                CMBF_TX_ACTIVE:
                    if (TX_STAT.done_ok || TX_STAT.fail)
                        tx_state_q <= CMBF_TX_IDLE;
                default:
                    tx_state_q <= CMBF_TX_IDLE;
            endcase
    end

    // data toward the engine comes from a flop, one cycle after the index
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            tx_byte_q <= 8'h00;
        else
            tx_byte_q <= tx_mem[sel_q][TX_BYTE_IDX];
    end

    assign TX_BYTE = tx_byte_q;

    // transmit flags per buffer; hardware sets win over software clears
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            txe_q   <= CMBF_TXE_RST;
            abak_q  <= 3'h0;
            abort_request_flag_q <= 3'h0;
        end
        else
            for (int i = 0; i < 3; i++)
            begin
                // sent frame frees its buffer, acknowledge reads zero
                if (tx_state_q == CMBF_TX_ACTIVE && TX_STAT.done_ok
                    && sel_q == 2'(i))
                begin
                    txe_q[i]   <= 1'b1;
                    abak_q[i]  <= 1'b0;
                    abort_request_flag_q[i] <= 1'b0;
                end
                // abort granted unless the buffer is on the bus
                // never release the buffer being picked for arbitration
                else if (abort_request_flag_q[i] && pend[i] &&
                         !(tx_state_q == CMBF_TX_ACTIVE && sel_q == 2'(i))
                         && !(tx_state_q == CMBF_TX_IDLE && TX_STAT.arb_start
                              && best == 2'(i)))
                begin
                    txe_q[i]   <= 1'b1;
                    abak_q[i]  <= 1'b1;
                    abort_request_flag_q[i] <= 1'b0;
                end
                else
                begin
                    if (wr_tx_flags && DAT_I[i] && txe_q[i])
                    begin
                        txe_q[i]  <= 1'b0;
                        abak_q[i] <= 1'b0;
                    end
                    // request only meaningful for a pending buffer
                    if (wb_wr && SEL_I[0] && ADR_I == CMBF_ADR_TX_CTRL
                        && DAT_I[i] && pend[i])
                        abort_request_flag_q[i] <= 1'b1;
                end
            end
    end

    // interrupt lines are level, gated by enables
    assign RX_IRQ  = rxf_q & ctrl_q[CMBF_CTRL_RXIE];
    assign ERR_IRQ = ovr_q & ctrl_q[CMBF_CTRL_OVRIE];
    assign TX_IRQ  = |(txe_q & ctrl_q[CMBF_CTRL_TXIE +: 3]);

    // helper for the priority check
    logic [7:0] sel_local_priority_field;
    assign sel_local_priority_field = tx_mem[sel_q][CMBF_LOCAL_PRIORITY_FIELD_IDX];

    a_tx_pin_level: assert property (@(posedge CLK) disable iff (!RST_N)
        TX_DOMINANT |=> !CAN_TX) else $error("dominant not driven low");
    a_rx_pin_sync: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(RST_N, 3) |-> RX_LEVEL == $past(CAN_RX, 2))
        else $error("receive pin not two flops late");
    a_fg_held_full: assert property (@(posedge CLK) disable iff (!RST_N)
        rxf_q |=> $stable(fg_mem[0]) && $stable(fg_mem[12]))
        else $error("foreground overwritten while full");
    a_closed_no_rxf: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == CMBF_FILT_CLOSED && !rxf_q && !bg_full_q) |=> !rxf_q)
        else $error("closed filter set receive full");
    a_own_no_copy: assert property (@(posedge CLK) disable iff (!RST_N)
        (RX_END.valid && RX_END.own && !loop_en && !rxf_q && !bg_full_q)
        |=> !rxf_q) else $error("own frame reached foreground");
    a_overrun_sets: assert property (@(posedge CLK) disable iff (!RST_N)
        (accepted && bg_full_q) |=> ovr_q && rxf_q)
        else $error("overrun not flagged");
    a_ovr_clear_refused: assert property (@(posedge CLK) disable iff (!RST_N)
        (ovr_q && bg_full_q) |=> ovr_q) else $error("overrun cleared early");
    a_hit_on_copy: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(hit_q) |-> $rose(rxf_q)) else $error("hit index moved");
    a_txe_on_done: assert property (@(posedge CLK) disable iff (!RST_N)
        (tx_state_q == CMBF_TX_ACTIVE && TX_STAT.done_ok)
        |=> txe_q[$past(sel_q)] && !abak_q[$past(sel_q)])
        else $error("sent buffer not released");
    a_local_priority_field_select: assert property (@(posedge CLK) disable iff (!RST_N)
        (tx_state_q == CMBF_TX_IDLE && TX_STAT.arb_start && |pend)
        |=> ($past(txe_q[0]) || sel_local_priority_field <= $past(tx_mem[0][CMBF_LOCAL_PRIORITY_FIELD_IDX]))
        && ($past(txe_q[1]) || sel_local_priority_field <= $past(tx_mem[1][CMBF_LOCAL_PRIORITY_FIELD_IDX]))
        && ($past(txe_q[2]) || sel_local_priority_field <= $past(tx_mem[2][CMBF_LOCAL_PRIORITY_FIELD_IDX])))
        else $error("wrong buffer priority");
    a_active_no_abort: assert property (@(posedge CLK) disable iff (!RST_N)
        (tx_state_q == CMBF_TX_ACTIVE && !TX_STAT.done_ok && !TX_STAT.fail)
        |=> !txe_q[$past(sel_q)]) else $error("active frame released");

endmodule

//--- test/cmbf_eng_model.sv
`timescale 1ns/1ns
module cmbf_eng_model
    import cmbf_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        CAN_TX,
    output logic             CAN_RX,
    output logic             TX_DOMINANT,
    output cmbf_rx_byte_type RX_BYTE,
    output cmbf_rx_end_type  RX_END,
    output cmbf_tx_stat_type TX_STAT,
    output logic [3:0]       TX_BYTE_IDX
);
    // lone node on the wire: bus follows our own pin, recessive when idle
    // wire level loops back
    assign CAN_RX = CAN_TX;
    // priority byte of the chosen buffer stays on show
    assign TX_BYTE_IDX = 4'hd;
    initial
    begin
        TX_DOMINANT = 1'b0;
        RX_BYTE = '0;
        RX_END = '0;
        TX_STAT = '0;
    end
    // all bytes land before the end strobe, a spare cycle between
    // whole frame then end
    task automatic frame(input logic [31:0] id, input logic own);
        for (int i = 0; i < 13; i++)
        begin
            @(posedge CLK);
            RX_BYTE <= {1'b1, 4'(i), (i < 4) ? id[8*i+:8] : 8'ha0 + 8'(i)};
        end
        @(posedge CLK);
        RX_BYTE <= {1'b0, 4'h0, 8'h5a};
        @(posedge CLK);
        RX_END <= {1'b1, 1'b1, own};
        @(posedge CLK);
        RX_END <= '0;
        repeat (2) @(posedge CLK);
    endtask
    // one pulse; the pin goes dominant from arbitration until the outcome
    task automatic tx(input cmbf_tx_stat_type s);
        @(posedge CLK);
        TX_STAT <= s;
        TX_DOMINANT <= s.arb_start;
        @(posedge CLK);
        TX_STAT <= '0;
    endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ns
module tb
    import cmbf_pkg::*;
();
    logic CLK = 0, RST_N = 0, CYC_I = 0, STB_I = 0, WE_I = 0;
    logic [8:0]  ADR_I = '0;
    logic [3:0]  SEL_I = 4'hf, TX_BYTE_IDX;
    logic [31:0] DAT_I = '0, DAT_O, r;
    logic ACK_O, CAN_RX, CAN_TX, RX_LEVEL, TX_DOMINANT, ACK_ALLOW;
    logic TX_REQUEST, RX_IRQ, TX_IRQ, ERR_IRQ;
    logic [7:0]  TX_BYTE;
    cmbf_rx_byte_type RX_BYTE;
    cmbf_rx_end_type  RX_END;
    cmbf_tx_stat_type TX_STAT;
    int error_cnt = 0, num_checks = 0;
    // filter table: mode, code, mask, frame identifier, expected flags
    logic [1:0]  md [6] = '{0, 0, 0, 1, 2, 3};
    logic [31:0] fc [6] = '{32'h12345678, 32'h12345678, 32'h12345678,
                            32'h56789abc, 32'h33332211, 32'h12345678};
    logic [31:0] fm [6] = '{0, 0, 32'h000000ff, 0, 0, 0};
    logic [31:0] fi [6] = '{32'h12345678, 32'h12345679, 32'h123456ff,
                            32'h00005678, 32'h00000033, 32'h12345678};
    logic [31:0] fe [6] = '{32'h01, 32'h00, 32'h01, 32'h11, 32'h21, 32'h20};
    always #50 CLK = ~CLK;
    cmbf_top cmbf_top_i (.CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I),
        .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CAN_RX(CAN_RX),
        .CAN_TX(CAN_TX), .RX_LEVEL(RX_LEVEL), .TX_DOMINANT(TX_DOMINANT),
        .ACK_ALLOW(ACK_ALLOW), .RX_BYTE(RX_BYTE), .RX_END(RX_END),
        .TX_STAT(TX_STAT), .TX_REQUEST(TX_REQUEST),
        .TX_BYTE_IDX(TX_BYTE_IDX), .TX_BYTE(TX_BYTE), .RX_IRQ(RX_IRQ),
        .TX_IRQ(TX_IRQ), .ERR_IRQ(ERR_IRQ));
    cmbf_eng_model cmbf_eng_model_i (.CLK(CLK), .CAN_TX(CAN_TX),
        .CAN_RX(CAN_RX), .TX_DOMINANT(TX_DOMINANT), .RX_BYTE(RX_BYTE),
        .RX_END(RX_END), .TX_STAT(TX_STAT), .TX_BYTE_IDX(TX_BYTE_IDX));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // classic cycle; ack and data taken at the rising edge, then released
    task automatic wb(input logic w, input logic [8:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge CLK);
        {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= {2'b11, w, a, 4'hf, d};
        do @(posedge CLK); while (ACK_O !== 1'b1);
        q = DAT_O;
        {CYC_I, STB_I, WE_I} <= 3'b000;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask
    // watchdog far beyond the few hundred cycles the tests take
    initial
    begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        settle(1);
        chk(CAN_TX, 1);
        wb(0, CMBF_ADR_TX_FLAGS, 0, r);
        chk(r, 32'h7);
        wb(0, 9'h018, 0, r);
        chk(r, 0);
        for (int k = 0; k < 6; k++)
        begin
            wb(1, CMBF_ADR_CTRL, {30'h4, md[k]}, r);
            wb(1, CMBF_ADR_ACODE, fc[k], r);
            wb(1, CMBF_ADR_AMASK, fm[k], r);
            cmbf_eng_model_i.frame(fi[k], 0);
            wb(0, CMBF_ADR_RX_FLAGS, 0, r);
            chk(r, fe[k]);
            chk(RX_IRQ, fe[k] & 1);
            wb(1, CMBF_ADR_RX_FLAGS, 32'h3, r);
        end
        wb(0, CMBF_ADR_FOREGROUND_RECEIVE_BUFFER + 9'h014, 0, r);
        chk(r, 32'ha5);
        // two held frames, the third one is dropped
        wb(1, CMBF_ADR_CTRL, 32'h20, r);
        repeat (3) cmbf_eng_model_i.frame(32'h12345678, 0);
        wb(0, CMBF_ADR_RX_FLAGS, 0, r);
        chk(r, 32'h3);
        chk(ERR_IRQ, 1);
        wb(1, CMBF_ADR_RX_FLAGS, 32'h3, r);
        wb(0, CMBF_ADR_RX_FLAGS, 0, r);
        chk(r, 32'h3);
        wb(1, CMBF_ADR_RX_FLAGS, 32'h3, r);
        cmbf_eng_model_i.frame(32'h12345678, 1);
        wb(0, CMBF_ADR_RX_FLAGS, 0, r);
        chk(r, 0);
        wb(1, CMBF_ADR_CTRL, 32'h04, r);
        cmbf_eng_model_i.frame(32'h12345678, 1);
        wb(0, CMBF_ADR_RX_FLAGS, 0, r);
        chk(r, 32'h1);
        // software loads priorities, then schedules; retry re-arbitrates
        // load then schedule
        wb(1, CMBF_ADR_CTRL, 32'h700, r);
        wb(1, CMBF_ADR_TXBUF + 9'h034, 32'h5, r);
        wb(1, CMBF_ADR_TXBUF + 9'h074, 32'h3, r);
        wb(1, CMBF_ADR_TX_FLAGS, 32'h1, r);
        chk(TX_REQUEST, 1);
        cmbf_eng_model_i.tx(3'b100);
        settle(3);
        chk(TX_BYTE, 32'h5);
        chk({CAN_TX, RX_LEVEL, ACK_ALLOW}, 0);
        cmbf_eng_model_i.tx(3'b001);
        // lost arbitration: the winner's frame arrives as a normal one
        wb(1, CMBF_ADR_RX_FLAGS, 32'h1, r);
        cmbf_eng_model_i.frame(32'h12345678, 0);
        wb(0, CMBF_ADR_RX_FLAGS, 0, r);
        chk(r, 32'h1);
        wb(1, CMBF_ADR_TX_FLAGS, 32'h2, r);
        cmbf_eng_model_i.tx(3'b100);
        settle(3);
        chk(TX_BYTE, 32'h3);
        wb(1, CMBF_ADR_TX_CTRL, 32'h1, r);
        wb(0, CMBF_ADR_TX_FLAGS, 0, r);
        chk(r, 32'h15);
        cmbf_eng_model_i.tx(3'b010);
        wb(0, CMBF_ADR_TX_FLAGS, 0, r);
        chk(r & 32'h7, 32'h7);
        chk(TX_IRQ, 1);
        stop_test();
    end
endmodule
